// *** rtl/dpp_pkg.sv ***
// Package: constants, pin carrier and state codes of the programming port
package dpp_pkg;
	// Bus widths and register count
	localparam int DATA_W   = 8;  // Parallel data and serial byte
	localparam int ADDR_W   = 6;  // Register address
	localparam int NUM_REGS = 64; // Buffer and active register count
	localparam int RW_BIT   = 7;  // Instruction bit: 1 = read

	// Update strobe pulse length in system clocks
	localparam logic [3:0] UPD_PULSE_CYC = 4'h8;
	// Last bit index of a serial byte
	localparam logic [2:0] BIT_LAST = 3'h7;
	// Datapath latencies in system clocks
	localparam logic [7:0] INV_SINC_LAT = 8'h10; // Correction stage, 16
	localparam logic [7:0] CORE_LAT     = 8'h20; // Remaining stages
	// Register contents after system reset
	localparam logic [7:0] REG_RESET = 8'h00;

	// Pin inputs that cross into the clock domain together
	typedef struct packed {
		logic [DATA_W-1:0] data; // Parallel data bus
		logic [ADDR_W-1:0] addr; // Address bus, low bits shared with serial
		logic              wr;   // Write strobe, serial clock
		logic              rd_n; // Read strobe, serial select
		logic              ser;  // High selects the serial port
		logic              upd;  // Update strobe as input
	} dpp_pins_t;

	// Pin levels after reset: both strobes idle high, parallel select
	localparam dpp_pins_t PINS_IDLE = '{data: 8'h00, addr: 6'h00,
		wr: 1'h1, rd_n: 1'h1, ser: 1'h0, upd: 1'h0};

	// Serial protocol states, Gray along the usual path
	typedef enum logic [1:0] {
		DPP_IDLE  = 2'b00,
		DPP_INSTR = 2'b01,
		DPP_DATA  = 2'b11
	} dpp_ser_state_t;

	// Rising edge of a synchronised level
	function automatic logic dpp_rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction : dpp_rise

	// Falling edge of a synchronised level
	function automatic logic dpp_fall(input logic now, input logic prev);
		return ~now & prev;
	endfunction : dpp_fall
endpackage : dpp_pkg

// *** rtl/dpp_port.sv ***
// Programming port: parallel and serial register access with update strobe
// Functional notes
// - Eight-bit data bus driven only in parallel mode
// - Six-bit address selects the accessed register
// - Serial mode reuses three low address pins
// - Serial reset idles link, keeps register contents
// - Three-wire reads drive dedicated output line
// - Two-wire mode shares one line both ways
// - Update strobe direction set by control; output default
// - Input strobe rising edge copies buffers to registers
// - Output strobe pulses eight clocks per update
// - Write strobe stores data into port buffer
// - Serial clock rising edge samples serial data
// - Select pin picks parallel or serial meaning
// - Inverse sinc adds sixteen cycles unless bypassed
// - Stage latency fixed, independent of tuning word
// - Read strobe reads parallel, frames serial transfers
module dpp_port (
	input  wire logic       i_clk,           // System clock
	input  wire logic       i_sys_rst,       // Synchronous reset
	input  wire logic       i_ce,            // Clock enable, freezes state
	input  wire logic [7:0] i_data,          // Parallel data bus in
	output logic      [7:0] o_data,          // Parallel data bus out
	output logic            o_data_oe,       // Parallel data bus drive
	input  wire logic [5:0] i_addr,          // Address bus, shared pins
	output logic            o_sdo,           // Serial out on address bit 1
	output logic            o_sdo_oe,        // Drive of address bit 1
	output logic            o_sdio,          // Serial out on address bit 0
	output logic            o_sdio_oe,       // Drive of address bit 0
	input  wire logic       i_wr,            // Write strobe, serial clock
	input  wire logic       i_rd_n,          // Read strobe, serial select
	input  wire logic       i_ser_select,    // High selects serial port
	input  wire logic       i_upd,           // Update strobe pin in
	output logic            o_upd,           // Update strobe pin out
	output logic            o_upd_oe,        // Update strobe pin drive
	input  wire logic       i_upd_dir_in,    // Control: strobe is input
	input  wire logic       i_three_wire,    // Control: 3-wire serial
	input  wire logic       i_freq_update,   // Internal update event
	input  wire logic       i_inv_sinc_byp,  // Control: bypass correction
	input  wire logic [5:0] i_act_addr,      // Datapath register select
	output logic      [7:0] o_act_data,      // Active register contents
	output logic      [7:0] o_latency        // Total pipeline latency
);
	// Pin synchroniser, first stage read only by the second
	dpp_pkg::dpp_pins_t     pins_meta;       // First stage
	dpp_pkg::dpp_pins_t     pins;            // Second stage, safe to use
	dpp_pkg::dpp_pins_t     pins_d;          // Delayed copy for edges
	// Storage
	logic [7:0]             port_buf [dpp_pkg::NUM_REGS]; // Port buffers
	logic [7:0]             act_reg  [dpp_pkg::NUM_REGS]; // Active regs
	// Serial engine
	dpp_pkg::dpp_ser_state_t ser_state;      // Protocol state
	logic [2:0]             bit_cnt;         // Bit within the byte
	logic [7:0]             rx_shift;        // Incoming bits
	logic [7:0]             tx_shift;        // Outgoing bits
	logic                   ser_read;        // Current access is a read
	logic [5:0]             ser_addr;        // Current serial address
	// Update strobe
	logic [3:0]             upd_cnt;         // Remaining pulse cycles
	// Decoded events
	logic                   sclk_rise;       // Serial clock rising
	logic                   sclk_fall;       // Serial clock falling
	logic                   par_wr_rise;     // Parallel write strobe end
	logic                   io_reset;        // Serial link reset
	logic                   ext_upd_rise;    // Host strobe rising
	logic                   do_transfer;     // Buffers to registers
	logic                   ser_active;      // Framed serial transfer
	logic                   ser_byte_done;   // Eighth bit sampled

	// Two-flop synchroniser on every pin input
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			// Idle strobe levels, so no false edge or read after reset
			pins_meta <= dpp_pkg::PINS_IDLE;
			pins      <= dpp_pkg::PINS_IDLE;
			pins_d    <= dpp_pkg::PINS_IDLE;
		end else if (i_ce) begin
			pins_meta <= {i_data, i_addr, i_wr, i_rd_n, i_ser_select, i_upd};
			pins      <= pins_meta;
			pins_d    <= pins;
		end
	end

	// Pin meaning decoded from the port select level
	always_comb begin
		sclk_rise    = pins.ser && dpp_pkg::dpp_rise(pins.wr, pins_d.wr);
		sclk_fall    = pins.ser && dpp_pkg::dpp_fall(pins.wr, pins_d.wr);
		par_wr_rise  = !pins.ser && dpp_pkg::dpp_rise(pins.wr, pins_d.wr);
		io_reset     = pins.ser && pins.addr[2];
		ser_active   = pins.ser && !pins.rd_n && !io_reset;
		ext_upd_rise = i_upd_dir_in && !o_upd_oe
			&& dpp_pkg::dpp_rise(pins.upd, pins_d.upd);
		do_transfer  = i_upd_dir_in ? ext_upd_rise : i_freq_update;
		ser_byte_done = sclk_rise && ser_active
			&& bit_cnt == dpp_pkg::BIT_LAST;
	end

	// Serial protocol: instruction byte, then one data byte, MSB first
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ser_state <= dpp_pkg::DPP_IDLE;
			bit_cnt   <= 3'h0;
			rx_shift  <= 8'h00;
			ser_read  <= 1'b0;
			ser_addr  <= 6'h00;
		end else if (i_ce) begin
			if (!ser_active) begin
				// Hung link or deselect: back to idle, registers untouched
				ser_state <= dpp_pkg::DPP_IDLE;
				bit_cnt   <= 3'h0;
			end else begin
				unique case (ser_state)
					dpp_pkg::DPP_IDLE: begin
						ser_state <= dpp_pkg::DPP_INSTR;
						bit_cnt   <= 3'h0;
					end
					dpp_pkg::DPP_INSTR: begin
						if (sclk_rise) begin
							// Data sampled on the serial clock rise
							rx_shift <= {rx_shift[6:0], pins.addr[0]};
							bit_cnt  <= bit_cnt + 3'h1;
						end
						if (ser_byte_done) begin
							ser_read  <= rx_shift[dpp_pkg::RW_BIT-1];
							ser_addr  <= {rx_shift[4:0], pins.addr[0]};
							ser_state <= dpp_pkg::DPP_DATA;
						end
					end
					dpp_pkg::DPP_DATA: begin
						if (sclk_rise) begin
							rx_shift <= {rx_shift[6:0], pins.addr[0]};
							bit_cnt  <= bit_cnt + 3'h1;
						end
						// Streaming: next instruction follows while framed
						if (ser_byte_done)
							ser_state <= dpp_pkg::DPP_INSTR;
					end
					default: begin
						ser_state <= dpp_pkg::DPP_IDLE;
					end
				endcase
			end
		end
	end

	// Outgoing read byte, loaded on the last instruction bit rise, shifted on serial clock falls
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tx_shift <= 8'h00;
		end else if (i_ce) begin
			if (ser_state == dpp_pkg::DPP_INSTR && ser_byte_done)
				tx_shift <= act_reg[{rx_shift[4:0], pins.addr[0]}];
			else if (ser_state == dpp_pkg::DPP_DATA && sclk_fall)
				tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	// Serial output pins; one cycle behind the shifter, far inside a bit
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_sdo     <= 1'b0;
			o_sdo_oe  <= 1'b0;
			o_sdio    <= 1'b0;
			o_sdio_oe <= 1'b0;
		end else if (i_ce) begin
			o_sdo     <= tx_shift[7];
			o_sdio    <= tx_shift[7];
			// Dedicated output line in 3-wire reads
			o_sdo_oe  <= ser_active && ser_read && i_three_wire
				&& ser_state == dpp_pkg::DPP_DATA;
			// Shared line turned round for 2-wire reads
			o_sdio_oe <= ser_active && ser_read && !i_three_wire
				&& ser_state == dpp_pkg::DPP_DATA;
		end
	end

	// Port buffers: parallel strobe or completed serial data byte
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < dpp_pkg::NUM_REGS; i++)
				port_buf[i] <= dpp_pkg::REG_RESET;
		end else if (i_ce) begin
			if (par_wr_rise)
				port_buf[pins.addr] <= pins.data;
			else if (ser_byte_done && ser_state == dpp_pkg::DPP_DATA
					&& !ser_read)
				port_buf[ser_addr] <= {rx_shift[6:0], pins.addr[0]};
		end
	end

	// Active registers take all buffers at once on an update
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < dpp_pkg::NUM_REGS; i++)
				act_reg[i] <= dpp_pkg::REG_RESET;
		end else if (i_ce && do_transfer) begin
			for (int i = 0; i < dpp_pkg::NUM_REGS; i++)
				act_reg[i] <= port_buf[i];
		end
	end

	// Update strobe: direction and eight-clock pulse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_upd_oe <= 1'b1; // Output after reset
			o_upd    <= 1'b0;
			upd_cnt  <= 4'h0;
		end else if (i_ce) begin
			o_upd_oe <= !i_upd_dir_in;
			if (i_upd_dir_in) begin
				// Pin belongs to the host; drop any pulse in flight
				o_upd   <= 1'b0;
				upd_cnt <= 4'h0;
			end else if (i_freq_update) begin
				o_upd   <= 1'b1;
				upd_cnt <= dpp_pkg::UPD_PULSE_CYC;
			end else if (upd_cnt != 4'h0) begin
				upd_cnt <= upd_cnt - 4'h1;
				o_upd   <= upd_cnt != 4'h1;
			end
		end
	end

	// Parallel read path; bus driven only in parallel mode
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_data    <= 8'h00;
			o_data_oe <= 1'b0;
		end else if (i_ce) begin
			o_data    <= act_reg[pins.addr];
			o_data_oe <= !pins.ser && !pins.rd_n;
		end
	end

	// Datapath view; latency does not look at the tuning word
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_act_data <= 8'h00;
			o_latency  <= dpp_pkg::CORE_LAT + dpp_pkg::INV_SINC_LAT;
		end else if (i_ce) begin
			o_act_data <= act_reg[i_act_addr];
			o_latency  <= i_inv_sinc_byp ? dpp_pkg::CORE_LAT
				: dpp_pkg::CORE_LAT + dpp_pkg::INV_SINC_LAT;
		end
	end

	// Checks, valid while the clock enable is held high
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst || !i_ce);

	AST_DATA_PAR_ONLY: assert property (
		o_data_oe |-> !$past(pins.ser) && !$past(pins.rd_n))
		else $error("data bus driven outside parallel read");
	AST_SDO_THREE_WIRE: assert property (
		o_sdo_oe |-> $past(i_three_wire) && !o_sdio_oe)
		else $error("serial output line driven outside 3-wire read");
	AST_SDIO_TWO_WIRE: assert property (
		o_sdio_oe |-> !$past(i_three_wire) && $past(ser_read))
		else $error("shared serial line driven outside 2-wire read");
	AST_IO_RESET_IDLE: assert property (
		io_reset |=> ser_state == dpp_pkg::DPP_IDLE && bit_cnt == 3'h0)
		else $error("serial reset did not idle the link");
	AST_UPD_PULSE_LEN: assert property (
		$rose(o_upd) ##0 (!i_freq_update && !i_upd_dir_in) [*8]
		|-> o_upd ##1 !o_upd)
		else $error("update pulse not eight clocks long");
	AST_UPD_OUT_DEFAULT: assert property (
		$fell(i_sys_rst) |-> o_upd_oe)
		else $error("update strobe not an output after reset");
	AST_PAR_WRITE: assert property (
		par_wr_rise |=> port_buf[$past(pins.addr)] == $past(pins.data))
		else $error("parallel write not stored in buffer");
	AST_EXT_TRANSFER: assert property (
		ext_upd_rise |=> act_reg[$past(i_act_addr)]
			== $past(port_buf[i_act_addr]))
		else $error("host strobe did not transfer buffers");
	AST_LATENCY: assert property (
		##1 o_latency == ($past(i_inv_sinc_byp) ? dpp_pkg::CORE_LAT
			: dpp_pkg::CORE_LAT + dpp_pkg::INV_SINC_LAT))
		else $error("latency does not follow bypass setting");

	// Host owns the strobe pin: nothing driven, no pulse
	AST_UPD_IN_QUIET: assert property (
		i_upd_dir_in |=> !o_upd && !o_upd_oe)
		else $error("update strobe driven while set as input");
	// Completed serial data byte lands in the addressed buffer
	AST_SER_WRITE: assert property (
		ser_byte_done && ser_state == dpp_pkg::DPP_DATA && !ser_read
		|=> port_buf[$past(ser_addr)]
			== $past({rx_shift[6:0], pins.addr[0]}))
		else $error("serial write not stored in buffer");
	// Serial output pins stay released in parallel mode
	AST_SER_PINS_PAR: assert property (
		!$past(pins.ser) |-> !o_sdo_oe && !o_sdio_oe)
		else $error("serial line driven in parallel mode");

	COV_SER_WRITE: cover property (ser_byte_done && !ser_read
		&& ser_state == dpp_pkg::DPP_DATA);
	COV_SER_READ: cover property (o_sdio_oe || o_sdo_oe);
	COV_PAR_WRITE: cover property (par_wr_rise);
	COV_UPD_PULSE: cover property ($fell(o_upd) && o_upd_oe);
	// Link reset arriving in the middle of a frame
	COV_IO_RESET: cover property (io_reset
		&& ser_state != dpp_pkg::DPP_IDLE);
endmodule : dpp_port

// *** testbench/dpp_pin_model.sv ***
// Host side pin model: resolves each shared pin between device and host
module dpp_pin_model #(
	parameter int W = 1 // Pin group width
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic [W-1:0] i_dev,     // Device drive value
	input  wire logic         i_dev_oe,  // Device drives the pin
	input  wire logic [W-1:0] i_host,    // Host drive value
	input  wire logic         i_host_oe, // Host drives the pin
	output logic      [W-1:0] o_wire     // Level seen on the pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] last = '0; // Last driven level
	// Remember the level while anyone drives
	always @(posedge i_clk) begin
		if (i_dev_oe || i_host_oe) begin
			last <= o_wire;
		end
	end
	// A released pin shows the inverse, so a stale read cannot match
	always_comb begin
		if (i_dev_oe) begin
			o_wire = i_dev;
		end else if (i_host_oe) begin
			o_wire = i_host; // Host address, data, strobe
		end else begin
			o_wire = ~last; // Turned-around shared line
		end
	end
endmodule : dpp_pin_model

// *** testbench/dds_programming_port_tb.sv ***
// Testbench: host driving the programming port against a reference model
module dds_programming_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, wr = 1, rd_n = 1, ser = 0, ce = 1;
	logic        upd_h = 0, dat_oe = 1, a0_oe = 1;   // Host drives
	logic        dir_in = 0, three = 0, fup = 0, byp = 0; // Controls
	logic [7:0]  dat_h = 0;                          // Host data
	logic [5:0]  adr_h = 0, act_a = 0, a;            // Addresses
	logic [7:0]  o_data, o_act, o_lat, w_dat, rv;    // Results
	logic        d_oe, sdo, sdo_oe, sdio, sdio_oe, upd, upd_oe;
	logic        w_sdo, w_sdio, w_upd;               // Pin levels
	logic [5:0]  aq [$];                             // Written addresses
	int          err_total = 0, checked = 0, n;
	int          buf_m [64] = '{default: 0};         // Model buffers
	int          act_m [64] = '{default: 0};         // Model registers
	logic [31:0] lf = 32'h0000_aeb6;                 // Random state
	// Clock, 10 MHz
	always #50 clk = ~clk;
	dpp_port u_dpp_port (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
		.i_data(w_dat), .o_data(o_data), .o_data_oe(d_oe),
		.i_addr({adr_h[5:2], w_sdo, w_sdio}), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .o_sdio(sdio), .o_sdio_oe(sdio_oe),
		.i_wr(wr), .i_rd_n(rd_n), .i_ser_select(ser), .i_upd(w_upd),
		.o_upd(upd), .o_upd_oe(upd_oe), .i_upd_dir_in(dir_in),
		.i_three_wire(three), .i_freq_update(fup),
		.i_inv_sinc_byp(byp), .i_act_addr(act_a), .o_act_data(o_act),
		.o_latency(o_lat));
	dpp_pin_model #(.W(8)) u_dpp_pin_model_d (.i_clk(clk),
		.i_dev(o_data), .i_dev_oe(d_oe), .i_host(dat_h),
		.i_host_oe(dat_oe), .o_wire(w_dat));
	dpp_pin_model u_dpp_pin_model_a1 (.i_clk(clk), .i_dev(sdo),
		.i_dev_oe(sdo_oe), .i_host(adr_h[1]), .i_host_oe(!ser),
		.o_wire(w_sdo));
	dpp_pin_model u_dpp_pin_model_a0 (.i_clk(clk), .i_dev(sdio),
		.i_dev_oe(sdio_oe), .i_host(adr_h[0]), .i_host_oe(a0_oe),
		.o_wire(w_sdio));
	dpp_pin_model u_dpp_pin_model_u (.i_clk(clk), .i_dev(upd),
		.i_dev_oe(upd_oe), .i_host(upd_h), .i_host_oe(dir_in),
		.o_wire(w_upd));
	// Shift register step for random values
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : rnd
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic clks(input int k);
		repeat (k) @(negedge clk);
	endtask : clks
	// Strobe held 4 clocks each way, beyond the 3 the syncs need
	task automatic pwr(input logic [5:0] ad, input logic [7:0] d);
		adr_h = ad;
		dat_h = d;
		clks(4);
		wr = 0;
		clks(4);
		wr = 1; // Rising end stores into the buffer
		clks(5);
		buf_m[ad] = d;
	endtask : pwr
	// Internal update; copy and pulse only in output mode
	task automatic pulse();
		fup = 1;
		clks(1);
		fup = 0;
		n = 0;
		repeat (12) begin
			if (upd === 1'b1) n++;
			clks(1);
		end
		chk(8'(n), dir_in ? 8'h00 : 8'h08);
		if (!dir_in) act_m = buf_m;
	endtask : pulse
	task automatic cact(input logic [5:0] ad);
		act_a = ad;
		clks(2);
		chk(o_act, 8'(act_m[ad]));
	endtask : cact
	// Parallel read with the host off the data bus
	task automatic prd(input logic [5:0] ad);
		adr_h = ad;
		dat_oe = 0;
		rd_n = 0;
		clks(4);
		chk(w_dat, 8'(act_m[ad]));
		rd_n = 1;
		clks(4);
		chk(d_oe, 8'h00);
		dat_oe = 1;
	endtask : prd
	// One serial bit, 800 ns link period; read bit taken before the fall
	task automatic sbit(input logic b, input int i);
		rv[i] = three ? w_sdo : w_sdio;
		adr_h[0] = b;
		wr = 0;
		clks(4);
		wr = 1;
		clks(4);
	endtask : sbit
	task automatic sbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) sbit(b[i], i);
	endtask : sbyte
	// Framed transfer: instruction then one data byte
	task automatic sxfer(input logic r, input logic [5:0] ad,
		input logic [7:0] d);
		rd_n = 0;
		clks(4);
		sbyte({r, 1'b0, ad});
		a0_oe = !(r && !three);
		sbyte(d);
		a0_oe = 1;
		chk(d_oe, 8'h00); // Bus idle in serial mode
		rd_n = 1;
		clks(4);
		if (!r) buf_m[ad] = d;
	endtask : sxfer
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// Watchdog, well past the expected run
	initial begin
		#500_000;
		err_total++;
		end_of_test();
	end
	// Main sequence
	initial begin
		clks(10);
		rst = 0;
		clks(2);
		chk(upd_oe, 8'h01); // Output after reset
		chk(o_lat, 8'h30);
		byp = 1;
		clks(3);
		chk(o_lat, 8'h20);
		byp = 0;
		$display("test reset done");
		// Boundary then random addresses; buffers not yet active
		for (int k = 0; k < 4; k++) begin
			lf = rnd(lf);
			a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : lf[5:0];
			aq.push_back(a);
			pwr(a, lf[15:8]);
			cact(a);
		end
		// Clock enable low: update event ignored, state frozen
		ce = 0;
		fup = 1;
		clks(1);
		fup = 0;
		clks(2);
		chk(upd, 8'h00);
		clks(10);
		ce = 1;
		cact(aq[1]);
		pulse();
		foreach (aq[i]) cact(aq[i]);
		foreach (aq[i]) prd(aq[i]);
		$display("test parallel done");
		// Host-driven strobe; internal event ignored until its edge
		dir_in = 1;
		clks(2);
		chk(upd_oe, 8'h00);
		pwr(6'h05, lf[23:16]);
		pulse();
		cact(6'h05);
		upd_h = 1;
		clks(6);
		act_m = buf_m;
		cact(6'h05);
		upd_h = 0;
		dir_in = 0;
		adr_h = 0;
		$display("test strobe input done");
		ser = 1;
		clks(4);
		for (int m = 0; m < 2; m++) begin
			three = m[0];
			lf = rnd(lf);
			a = lf[13:8];
			sxfer(0, a, lf[7:0]);
			pulse();
			cact(a);
			sxfer(1, a, 8'h00);
			chk(rv, 8'(act_m[a]));
		end
		// Link reset mid-byte, frame kept open, then a clean write
		rd_n = 0;
		clks(4);
		for (int i = 0; i < 4; i++) sbit(1'b1, i);
		adr_h[2] = 1;
		clks(4);
		adr_h[2] = 0;
		clks(4);
		sbyte(8'h2a);
		sbyte(8'h5a);
		rd_n = 1;
		clks(4);
		buf_m[6'h2a] = 8'h5a;
		pulse();
		cact(6'h2a);
		cact(a); // Earlier contents kept
		$display("test serial done");
		end_of_test();
	end
endmodule : dds_programming_port_tb
